//--- dv/host_model.sv
// Host processor model driving the port pins.
// Assumes the bench resolves the data bus.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic [7:0] bus,
    output logic [2:0] addr,
    output host_port_pkg::host_ctrl_t ctrl,
    output logic [7:0] drv
);
    import host_port_pkg::*;
    // ======================================
    // Bus cycle; address strobe idles low
    initial {addr, ctrl, drv} = {3'h0, 8'h2a, 8'h00};
    task automatic access(input logic wr, hi, lat, input logic [2:0] a,
        input logic [7:0] d, input logic [2:0] sel, output logic [7:0] q);
        @(negedge clk);
        {addr, drv} = {a, wr ? d : ~d};
        ctrl[7:5] = sel ^ 3'h1;
        repeat (6) @(negedge clk);
        if (lat) begin
            ctrl.address_latch_strobe = 1'b1;
            repeat (6) @(negedge clk);
            {addr, ctrl[5]} = {~a, 1'b1};
        end
        // Pins pass a sync chain, so each phase lasts several cycles
        // hi picks the high-true strobe, else the low-true one goes low
        ctrl[4:1] = wr ? {2'b01, hi, hi} : {hi, hi, 2'b01};
        repeat (10) @(negedge clk);
        q = bus;
        ctrl[4:1] = 4'h5;
        repeat (8) @(negedge clk);
        ctrl = 8'h2a;
        repeat (6) @(negedge clk);
    endtask
endmodule
`default_nettype wire

//--- dv/host_port_chk_sva.sv
// Checker on the host port outputs.
// Assumes it is bound onto the port module.
`timescale 1ns/1ps
`default_nettype none
module host_port_chk (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic [7:0] HOST_DATA_OUT,
    input wire logic HOST_DATA_OE,
    input wire logic DRIVE_DISABLE_N,
    input wire logic [7:0] CORE_RD_DATA,
    input wire logic [2:0] CORE_ADDR,
    input wire logic CORE_RD_STROBE,
    input wire logic CORE_WR_STROBE
);
    // ======================================
    // Output relations on the system clock
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    a_drive_disable_n_read: assert property (DRIVE_DISABLE_N == !HOST_DATA_OE)
        else $error("drive disable wrong");
    a_rd_then_oe: assert property (CORE_RD_STROBE |=> HOST_DATA_OE)
        else $error("no drive after read");
    a_oe_cause: assert property ($rose(HOST_DATA_OE)
        |-> $past(CORE_RD_STROBE)) else $error("drive without read");
    a_rd_data: assert property (HOST_DATA_OE
        |-> HOST_DATA_OUT == CORE_RD_DATA) else $error("read data wrong");
    a_addr_hold: assert property (HOST_DATA_OE && $past(HOST_DATA_OE)
        |-> $stable(CORE_ADDR)) else $error("address moved");
    a_rd_pulse: assert property (CORE_RD_STROBE |=> !CORE_RD_STROBE)
        else $error("read pulse long");
    a_wr_pulse: assert property (CORE_WR_STROBE |=> !CORE_WR_STROBE)
        else $error("write pulse long");
    a_wr_no_drive: assert property (CORE_WR_STROBE |-> !HOST_DATA_OE)
        else $error("drive during write");
endmodule
bind uart_host_bus_port host_port_chk i_host_port_chk (.SYS_CLK, .RESET_N,
    .HOST_DATA_OUT, .HOST_DATA_OE, .DRIVE_DISABLE_N, .CORE_RD_DATA,
    .CORE_ADDR, .CORE_RD_STROBE, .CORE_WR_STROBE);
`default_nettype wire

//--- dv/test_uart_host_bus_port.sv
// Self-checking bench for the host bus port.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_uart_host_bus_port;
    import host_port_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic oe, drive_disable_n_n, rd_stb, wr_stb;
    logic [2:0] addr, core_addr, a;
    logic [7:0] out, drv, bus, wr_data, q, d;
    host_ctrl_t ctrl;
    int fail_count = 0, samples_checked = 0, cycles = 0, writes = 0, w0;
    // ======================================
    // Core registers answer a fixed pattern
    function automatic logic [7:0] reg_val(input logic [2:0] x);
        return 8'ha5 ^ {x, x, x[2:1]};
    endfunction
    assign bus = oe ? out : drv;
    always #5 clk = ~clk;
    uart_host_bus_port i_uart_host_bus_port (.SYS_CLK(clk), .RESET_N(rst_n),
        .REG_SELECT(addr), .HOST_CTRL(ctrl), .HOST_DATA_IN(bus),
        .HOST_DATA_OUT(out), .HOST_DATA_OE(oe), .DRIVE_DISABLE_N(drive_disable_n_n),
        .CORE_RD_DATA(reg_val(core_addr)), .CORE_ADDR(core_addr),
        .CORE_RD_STROBE(rd_stb), .CORE_WR_STROBE(wr_stb),
        .CORE_WR_DATA(wr_data));
    host_model i_host_model (.clk(clk), .bus(bus), .addr(addr),
        .ctrl(ctrl), .drv(drv));
    task automatic check(input string what, input logic [7:0] exp, got);
        samples_checked++;
        if (got !== exp) fail_count++;
        if (got !== exp) $display("mismatch %s %h %h", what, exp, got);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Hang limit; write pulses are tallied
    always @(posedge clk) begin
        cycles++;
        if (wr_stb === 1'b1) writes++;
        if (cycles == 20000) fail_count++;
        if (cycles == 20000) summarize;
    end
    initial begin
        void'($urandom(65));
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        // All registers, both strobe forms
        for (int i = 0; i < 16; i++) begin
            a = i[2:0];
            d = 8'($urandom);
            w0 = writes;
            i_host_model.access(1'b1, i[3], 1'b0, a, d, 3'h7, q);
            check("wr count", 8'(w0 + 1), 8'(writes));
            check("wr addr", {5'h0, a}, {5'h0, core_addr});
            check("wr data", d, wr_data);
            i_host_model.access(1'b0, i[3], 1'b0, a, d, 3'h7, q);
            check("rd data", reg_val(a), q);
        end
        $display("access test done");
        // One select withdrawn at a time
        for (int j = 0; j < 3; j++) begin
            a = 3'h7 ^ (3'h1 << j);
            w0 = writes;
            i_host_model.access(1'b1, 1'b0, 1'b0, 3'h2, 8'h3c, a, q);
            check("refused wr", 8'(w0), 8'(writes));
            i_host_model.access(1'b0, 1'b1, 1'b0, 3'h2, 8'h00, a, q);
            check("float bus", 8'hff, q);
        end
        $display("select test done");
        d = 8'($urandom);
        i_host_model.access(1'b1, 1'b0, 1'b1, 3'h5, d, 3'h7, q);
        check("latch addr", 8'h05, {5'h0, core_addr});
        $display("latch test done");
        summarize;
    end
endmodule
`default_nettype wire

//--- rtl/host_port_pkg.sv
// Package for the parallel host bus port of the UART.
// Assumes a single 100 MHz system clock; holds widths, codes and types.
`default_nettype none

package host_port_pkg;

    // ==========================================================
    // Widths and constants
    localparam int DATA_WIDTH = 8;
    localparam int ADDR_WIDTH = 3;
    localparam int SYNC_DEPTH = 3;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [2:0] ADDR_RESET = 3'h0;
    localparam logic [2:0] SYNC_RESET = 3'h0;
    // Control pins at rest: selects off, strobes released, latch strobe low
    localparam logic [7:0] CTRL_IDLE = 8'h2a;

    // ==========================================================
    // Raw control pins as they arrive from the host
    typedef struct packed {
        logic select_high_a;
        logic select_high_b;
        logic select_low;
        logic read_strobe_high;
        logic read_strobe_low;
        logic write_strobe_high;
        logic write_strobe_low;
        logic address_latch_strobe;
    } host_ctrl_t;

    // Decoded address phase, latched or passed through
    typedef struct packed {
        logic selected;
        logic [ADDR_WIDTH-1:0] reg_select;
    } addr_phase_t;

    // Access state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } access_state_t;

endpackage

`default_nettype wire

//--- rtl/uart_host_bus_port.sv
// Parallel host bus port of a 16550-class UART: register selects,
// chip selects, dual-polarity strobes, address strobe and data bus.
// Assumes the UART core answers reads combinationally from CORE_RD_DATA.
// Assumes all host pins are asynchronous to SYS_CLK and rest at their
// released levels: selects off, strobes off, address strobe low.
// Host strobes and data must stand for at least two clock cycles,
// since every pin passes the same three-stage filter.
`timescale 1ns/1ps
`default_nettype none

module uart_host_bus_port (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic [host_port_pkg::ADDR_WIDTH-1:0] REG_SELECT,
    input wire host_port_pkg::host_ctrl_t HOST_CTRL,
    input wire logic [host_port_pkg::DATA_WIDTH-1:0] HOST_DATA_IN,
    output logic [host_port_pkg::DATA_WIDTH-1:0] HOST_DATA_OUT,
    output logic HOST_DATA_OE,
    output logic DRIVE_DISABLE_N,
    input wire logic [host_port_pkg::DATA_WIDTH-1:0] CORE_RD_DATA,
    output logic [host_port_pkg::ADDR_WIDTH-1:0] CORE_ADDR,
    output logic CORE_RD_STROBE,
    output logic CORE_WR_STROBE,
    output logic [host_port_pkg::DATA_WIDTH-1:0] CORE_WR_DATA
);
    import host_port_pkg::*;

    // ==========================================================
    // Input synchronisers
    // Pins are asynchronous to SYS_CLK; a level counts once the second
    // and third stages agree, which also filters one-cycle glitches.
    localparam int NSIG = 8 + ADDR_WIDTH + DATA_WIDTH;
    // Resting level of every pin, so reset release shows no false edge
    localparam logic [NSIG-1:0] PIN_IDLE = {CTRL_IDLE, ADDR_RESET,
        DATA_RESET};
    logic [NSIG-1:0] raw_in;
    logic [NSIG-1:0] sync1;
    logic [NSIG-1:0] sync2;
    logic [NSIG-1:0] sync3;
    logic [NSIG-1:0] stable;
    logic [NSIG-1:0] next_stable;

    // Pins enter as one vector: control, register select, data
    assign raw_in = {HOST_CTRL, REG_SELECT, HOST_DATA_IN};

    // Three-stage chain; only the second stage reads the first
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1 <= PIN_IDLE;
            sync2 <= PIN_IDLE;
            sync3 <= PIN_IDLE;
            stable <= PIN_IDLE;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
            sync3 <= sync2;
            stable <= next_stable;
        end
    end

    // Per-bit agreement filter
    genvar gi;
    generate
        for (gi = 0; gi < NSIG; gi++) begin : g_filt
            always_comb begin
                next_stable[gi] = (sync2[gi] == sync3[gi]) ?
                    sync3[gi] : stable[gi];
            end
        end
    endgenerate

    // Filtered pins split back into their fields
    host_ctrl_t ctrl;
    logic [ADDR_WIDTH-1:0] sel_pins;
    logic [DATA_WIDTH-1:0] data_pins;
    assign ctrl = host_ctrl_t'(stable[NSIG-1 -: 8]);
    assign sel_pins = stable[DATA_WIDTH +: ADDR_WIDTH];
    assign data_pins = stable[DATA_WIDTH-1:0];

    // ==========================================================
    // Address phase: latch on strobe rising edge, else pass through
    // Phase held from the last strobe edge; phase feeds the decode
    addr_phase_t live_phase;
    addr_phase_t held_phase;
    addr_phase_t next_held_phase;
    addr_phase_t phase;
    logic as_prev;
    logic next_as_prev;

    always_comb begin
        live_phase.selected = ctrl.select_high_a & ctrl.select_high_b
            & ~ctrl.select_low;
        live_phase.reg_select = sel_pins;
        next_as_prev = ctrl.address_latch_strobe;
        next_held_phase = held_phase;
        if (ctrl.address_latch_strobe && !as_prev) begin
            next_held_phase = live_phase;
        end
        // Strobe high keeps the captured values; low lets pins through
        phase = as_prev ? held_phase : live_phase;
    end

    // Address phase registers
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            held_phase <= '{selected: 1'b0, reg_select: ADDR_RESET};
            as_prev <= 1'b0;
        end else begin
            held_phase <= next_held_phase;
            as_prev <= next_as_prev;
        end
    end

    // ==========================================================
    // Strobe decode and access control
    logic rd_active;
    logic wr_active;
    logic wr_high_prev;
    logic next_wr_high_prev;
    logic wr_high_rise;
    access_state_t state;
    access_state_t next_state;
    logic [DATA_WIDTH-1:0] next_data_out;
    logic [DATA_WIDTH-1:0] next_wr_data;
    logic [ADDR_WIDTH-1:0] next_addr;
    logic next_oe;
    logic next_drive_disable_n_n;
    logic next_rd_stb;
    logic next_wr_stb;

    // Next-state and output decode; a read wins over a write
    always_comb begin
        rd_active = ~ctrl.read_strobe_low | ctrl.read_strobe_high;
        wr_high_rise = ctrl.write_strobe_high & ~wr_high_prev;
        // Write is launched once per strobe; both forms start on their level
        wr_active = ~ctrl.write_strobe_low | ctrl.write_strobe_high;
        next_wr_high_prev = ctrl.write_strobe_high;
        next_state = state;
        next_rd_stb = 1'b0;
        next_wr_stb = 1'b0;
        next_addr = CORE_ADDR;
        next_wr_data = CORE_WR_DATA;
        next_data_out = HOST_DATA_OUT;
        next_oe = 1'b0;
        next_drive_disable_n_n = 1'b1;
        unique case (state)
            ST_IDLE: begin
                if (phase.selected && rd_active) begin
                    next_state = ST_READ;
                    next_addr = phase.reg_select;
                    next_rd_stb = 1'b1;
                end else if (phase.selected && wr_active) begin
                    next_state = ST_WRITE;
                    next_addr = phase.reg_select;
                end
            end
            ST_READ: begin
                // Bit 0 of the core word is bus bit 0, the LSB
                next_data_out = CORE_RD_DATA;
                next_oe = rd_active && phase.selected;
                next_drive_disable_n_n = ~next_oe;
                if (!rd_active || !phase.selected) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WRITE: begin
                // Data is taken at strobe release, where it is surest, or when the high-true strobe rises anew
                if (!wr_active || wr_high_rise) begin
                    next_wr_data = data_pins;
                    next_wr_stb = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Every output is a flip-flop, so the host sees no decode glitches
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= ST_IDLE;
            wr_high_prev <= 1'b0;
            CORE_ADDR <= ADDR_RESET;
            CORE_WR_DATA <= DATA_RESET;
            HOST_DATA_OUT <= DATA_RESET;
            HOST_DATA_OE <= 1'b0;
            DRIVE_DISABLE_N <= 1'b1;
            CORE_RD_STROBE <= 1'b0;
            CORE_WR_STROBE <= 1'b0;
        end else begin
            state <= next_state;
            wr_high_prev <= next_wr_high_prev;
            CORE_ADDR <= next_addr;
            CORE_WR_DATA <= next_wr_data;
            HOST_DATA_OUT <= next_data_out;
            HOST_DATA_OE <= next_oe;
            DRIVE_DISABLE_N <= next_drive_disable_n_n;
            CORE_RD_STROBE <= next_rd_stb;
            CORE_WR_STROBE <= next_wr_stb;
        end
    end

endmodule

`default_nettype wire
